// [core/ccsd_top.sv]
// configuration loader, mode select and output divider decode
// Overview of operation
// - copy chosen default set on reset release
// - set chosen by pin or bit, per source
// - host writes override loaded working registers
// - host values lost; reset reloads defaults
// - two-bit field selects three loop modes
// - mode unchanged when default set changes
// - same divider decode; per-set divider value
// - eleven-bit divider gives ratios 2 to 2046
// - 0-2 give two, 3-5 themselves, else even
// - synthesis uses upper loop from crystal
// - upper feedback divider allows fractional ratio
// - high bandwidth: upper loop, pre-divided reference
// - monitor inputs, report as bit and pin
// - manual, revertive, non-revertive reference switching
// - pin low picks set zero, high set one
//
// Our own choices: the register addresses and the address-and-strobe port.
`include "ccsd_params.svh"
`default_nettype none
module ccsd_top #(
    parameter logic [15:0] SET0_CTRL = 16'h0000,
    parameter logic [15:0] SET0_DIV = 16'h0004,
    parameter logic [15:0] SET0_FBDIV = 16'h0050,
    parameter logic [15:0] SET0_FRAC = 16'h0000,
    parameter logic [15:0] SET0_PREDIV = 16'h0001,
    parameter logic [15:0] SET1_CTRL = 16'h0000,
    parameter logic [15:0] SET1_DIV = 16'h0008,
    parameter logic [15:0] SET1_FBDIV = 16'h0060,
    parameter logic [15:0] SET1_FRAC = 16'h0000,
    parameter logic [15:0] SET1_PREDIV = 16'h0002
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic set_select_pin,
    input wire logic ref_sel_pin,
    input wire logic ref_a_bad,
    input wire logic ref_b_bad,
    input wire logic xtal_bad,
    output logic [1:0] loop_mode,
    output logic mode_reserved,
    output logic [11:0] out_div_ratio,
    output logic [10:0] fb_div_int,
    output logic [15:0] fb_div_frac,
    output logic fb_frac_en,
    output logic [7:0] pre_div,
    output logic xtal_double,
    output logic upper_loop_only,
    output logic upper_from_xtal,
    output logic ref_inputs_used,
    output logic active_ref_b,
    output logic alarm_pin,
    output logic load_done
);
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic [15:0] div_ff, nxt_div;
    logic [15:0] fbdiv_ff, nxt_fbdiv;
    logic [15:0] frac_ff, nxt_frac;
    logic [15:0] prediv_ff, nxt_prediv;
    logic [2:0] load_idx_ff, nxt_load_idx;
    ccsd_pkg::ccsd_state_e state_ff, nxt_state;
    logic set_sel;
    logic [15:0] def_word;
    logic [11:0] ratio;
    logic ref_b_ff, nxt_ref_b;
    logic [15:0] rdata_ff, nxt_rdata;
    logic [1:0] mode_ff, nxt_mode;
    logic rsvd_ff, nxt_rsvd;
    logic [11:0] ratio_ff;
    logic [10:0] fbi_ff;
    logic [15:0] fbf_ff;
    logic fbe_ff, pass_dbl_ff, upper_only_ff, from_xtal_ff, refs_used_ff;
    logic [7:0] pre_ff;
    logic alarm_ff, done_ff;
    ccsd_pkg::ccsd_sw_e sw_mode;

    // set source: pin when source bit clear, else register bit
    assign set_sel = ctrl_ff[`CCSD_CTRL_SRC_BIT] ? ctrl_ff[`CCSD_CTRL_SET_BIT]
                                                 : set_select_pin;
    assign sw_mode = ccsd_pkg::ccsd_sw_e'(ctrl_ff[`CCSD_CTRL_SWMODE_LSB +: 2]);

    // default word for the loader step; per-set values for all five words, mode included
    always_comb begin
        def_word = 16'h0000;
        case (load_idx_ff)
            3'h0: def_word = set_sel ? SET1_CTRL : SET0_CTRL;
            3'h1: def_word = set_sel ? SET1_DIV : SET0_DIV;
            3'h2: def_word = set_sel ? SET1_FBDIV : SET0_FBDIV;
            3'h3: def_word = set_sel ? SET1_FRAC : SET0_FRAC;
            3'h4: def_word = set_sel ? SET1_PREDIV : SET0_PREDIV;
            default: def_word = 16'h0000;
        endcase
    end

    // loader and register writes; reset clears everything so nothing survives
    always_comb begin
        nxt_state = state_ff;
        nxt_load_idx = load_idx_ff;
        nxt_ctrl = ctrl_ff;
        nxt_div = div_ff;
        nxt_fbdiv = fbdiv_ff;
        nxt_frac = frac_ff;
        nxt_prediv = prediv_ff;
        case (state_ff)
            ccsd_pkg::CCSD_ST_LOAD: begin
                // source and set bits are cleared, not taken from the loaded word, so set choice
                // stays with the pin, since ctrl is zero at reset
                case (load_idx_ff)
                    3'h0: nxt_ctrl = {def_word[15:4], 1'b0, 1'b0, def_word[1:0]};
                    3'h1: nxt_div = def_word;
                    3'h2: nxt_fbdiv = def_word;
                    3'h3: nxt_frac = def_word;
                    3'h4: nxt_prediv = def_word;
                    default: nxt_ctrl = ctrl_ff;
                endcase
                nxt_load_idx = load_idx_ff + 3'h1;
                if (load_idx_ff == `CCSD_LOAD_WORDS - 3'h1) begin
                    nxt_state = ccsd_pkg::CCSD_ST_RUN;
                end
            end
            ccsd_pkg::CCSD_ST_RUN: begin
                if (reg_wr) begin
                    case (reg_addr)
                        `CCSD_ADDR_CTRL: nxt_ctrl = reg_wdata;
                        `CCSD_ADDR_DIV: nxt_div = reg_wdata;
                        `CCSD_ADDR_FBDIV: nxt_fbdiv = reg_wdata;
                        `CCSD_ADDR_FRAC: nxt_frac = reg_wdata;
                        `CCSD_ADDR_PREDIV: nxt_prediv = reg_wdata;
                        default: nxt_ctrl = ctrl_ff;
                    endcase
                end
                // a change of set reloads the divider words; the whole ctrl word, mode field included, is kept
                if (reg_wr && reg_addr == `CCSD_ADDR_CTRL &&
                        (reg_wdata[`CCSD_CTRL_SRC_BIT] != ctrl_ff[`CCSD_CTRL_SRC_BIT] ||
                         reg_wdata[`CCSD_CTRL_SET_BIT] != ctrl_ff[`CCSD_CTRL_SET_BIT])) begin
                    nxt_state = ccsd_pkg::CCSD_ST_IDLE;
                end else if (!ctrl_ff[`CCSD_CTRL_SRC_BIT] && set_select_pin != ref_b_ff) begin
                    nxt_state = ccsd_pkg::CCSD_ST_IDLE;
                end
            end
            ccsd_pkg::CCSD_ST_IDLE: begin
                // reload divider words of the newly chosen set, keep ctrl
                nxt_load_idx = 3'h1;
                nxt_state = ccsd_pkg::CCSD_ST_LOAD;
            end
            default: nxt_state = ccsd_pkg::CCSD_ST_LOAD;
        endcase
    end

    // ref_b_ff here tracks the last pin level seen, so a pin edge in run with the source bit clear triggers a reload
    always_comb begin
        nxt_ref_b = set_select_pin;
    end

    // divider decode: 0-2 -> 2, 3-5 -> self, above -> lsb cleared
    always_comb begin
        if (div_ff[10:0] <= 11'h002) begin
            ratio = `CCSD_DIV_MIN;
        end else if (div_ff[10:0] <= `CCSD_DIV_SMALL_MAX) begin
            ratio = {1'b0, div_ff[10:0]};
        end else begin
            ratio = {1'b0, div_ff[10:1], 1'b0};
        end
    end

    // mode mapping and reserved-mode flag
    always_comb begin
        nxt_mode = ctrl_ff[`CCSD_CTRL_MODE_LSB +: 2];
        nxt_rsvd = (ctrl_ff[1:0] == ccsd_pkg::CCSD_MODE_RSVD);
    end

    // register read, data one cycle later
    always_comb begin
        nxt_rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `CCSD_ADDR_CTRL: nxt_rdata = ctrl_ff;
                `CCSD_ADDR_DIV: nxt_rdata = div_ff;
                `CCSD_ADDR_FBDIV: nxt_rdata = fbdiv_ff;
                `CCSD_ADDR_FRAC: nxt_rdata = frac_ff;
                `CCSD_ADDR_PREDIV: nxt_rdata = prediv_ff;
                // status: load done, set in use, alarms
                `CCSD_ADDR_STATUS: nxt_rdata = {10'h000, active_ref_b, set_sel,
                    xtal_bad, ref_b_bad, ref_a_bad, done_ff};
                `CCSD_ADDR_DECODE: nxt_rdata = {4'h0, ratio};
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ccsd_pkg::CCSD_ST_LOAD;
            load_idx_ff <= 3'h0;
            ctrl_ff <= 16'h0000;
            div_ff <= 16'h0000;
            fbdiv_ff <= 16'h0000;
            frac_ff <= 16'h0000;
            prediv_ff <= 16'h0000;
            ref_b_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            mode_ff <= 2'b00;
            rsvd_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            load_idx_ff <= nxt_load_idx;
            ctrl_ff <= nxt_ctrl;
            div_ff <= nxt_div;
            fbdiv_ff <= nxt_fbdiv;
            frac_ff <= nxt_frac;
            prediv_ff <= nxt_prediv;
            ref_b_ff <= nxt_ref_b;
            rdata_ff <= nxt_rdata;
            mode_ff <= nxt_mode;
            rsvd_ff <= nxt_rsvd;
        end
    end

    // reference choice: manual by pin or bit, automatic with revert option
    logic nxt_active, active_ff;
    always_comb begin
        nxt_active = active_ff;
        case (sw_mode)
            ccsd_pkg::CCSD_SW_MAN_PIN: nxt_active = ref_sel_pin;
            ccsd_pkg::CCSD_SW_MAN_REG: nxt_active = ctrl_ff[`CCSD_CTRL_REFSEL_BIT];
            ccsd_pkg::CCSD_SW_REVERT: begin
                if (!(ctrl_ff[`CCSD_CTRL_REFSEL_BIT] ? ref_b_bad : ref_a_bad)) begin
                    nxt_active = ctrl_ff[`CCSD_CTRL_REFSEL_BIT];
                end else if (!(ctrl_ff[`CCSD_CTRL_REFSEL_BIT] ? ref_a_bad : ref_b_bad)) begin
                    nxt_active = !ctrl_ff[`CCSD_CTRL_REFSEL_BIT];
                end
            end
            ccsd_pkg::CCSD_SW_NONREV: begin
                if ((active_ff ? ref_b_bad : ref_a_bad) &&
                        !(active_ff ? ref_a_bad : ref_b_bad)) begin
                    nxt_active = !active_ff;
                end
            end
            default: nxt_active = active_ff;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_ff <= 1'b0;
            ratio_ff <= `CCSD_DIV_MIN;
            fbi_ff <= 11'h000;
            fbf_ff <= 16'h0000;
            fbe_ff <= 1'b0;
            pre_ff <= 8'h00;
            pass_dbl_ff <= 1'b0;
            upper_only_ff <= 1'b0;
            from_xtal_ff <= 1'b0;
            refs_used_ff <= 1'b0;
            alarm_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            active_ff <= nxt_active;
            ratio_ff <= ratio; // same decode in every mode
            fbi_ff <= fbdiv_ff[10:0];
            fbf_ff <= frac_ff; // fractional part feeds the modulator
            fbe_ff <= (frac_ff != 16'h0000);
            pre_ff <= prediv_ff[7:0];
            pass_dbl_ff <= ctrl_ff[`CCSD_CTRL_DBL_BIT];
            upper_only_ff <= (ctrl_ff[1:0] != ccsd_pkg::CCSD_MODE_LOW_BW);
            from_xtal_ff <= (ctrl_ff[1:0] == ccsd_pkg::CCSD_MODE_SYNTH);
            refs_used_ff <= (ctrl_ff[1:0] != ccsd_pkg::CCSD_MODE_SYNTH);
            alarm_ff <= ref_a_bad | ref_b_bad | xtal_bad;
            done_ff <= (state_ff == ccsd_pkg::CCSD_ST_RUN);
        end
    end

    assign reg_rdata = rdata_ff;
    assign loop_mode = mode_ff;
    assign mode_reserved = rsvd_ff;
    assign out_div_ratio = ratio_ff;
    assign fb_div_int = fbi_ff;
    assign fb_div_frac = fbf_ff;
    assign fb_frac_en = fbe_ff;
    assign pre_div = pre_ff;
    assign xtal_double = pass_dbl_ff;
    assign upper_loop_only = upper_only_ff;
    assign upper_from_xtal = from_xtal_ff;
    assign ref_inputs_used = refs_used_ff;
    assign active_ref_b = active_ff;
    assign alarm_pin = alarm_ff;
    assign load_done = done_ff;

    a_load_after_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> ##6 load_done) else $error("load not done");
    a_div_min_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
        out_div_ratio >= 12'h002) else $error("ratio below two");
    a_div_even_big: assert property (@(posedge sys_clk) disable iff (!rst_n)
        out_div_ratio > 12'h005 |-> !out_div_ratio[0]) else $error("odd ratio");
    a_div_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 out_div_ratio == (($past(div_ff[10:0]) <= 11'h002) ? 12'h002 :
        ($past(div_ff[10:0]) <= 11'h005) ? {1'b0, $past(div_ff[10:0])} :
        {1'b0, $past(div_ff[10:1]), 1'b0})) else $error("decode wrong");
    a_write_applies: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_ff == ccsd_pkg::CCSD_ST_RUN && reg_wr && reg_addr == `CCSD_ADDR_DIV
        |=> div_ff == $past(reg_wdata)) else $error("write lost");
    // a set reload walks idle and load steps 1-4; none of them may touch the mode
    a_mode_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_ff == ccsd_pkg::CCSD_ST_IDLE ||
        (state_ff == ccsd_pkg::CCSD_ST_LOAD && load_idx_ff != 3'h0)
        |=> $stable(ctrl_ff[1:0])) else $error("mode changed");
    a_synth_xtal: assert property (@(posedge sys_clk) disable iff (!rst_n)
        loop_mode == ccsd_pkg::CCSD_MODE_SYNTH |-> upper_from_xtal && upper_loop_only &&
        !ref_inputs_used) else $error("synth not xtal");
    a_alarm_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
        xtal_bad |=> alarm_pin) else $error("alarm missing");
endmodule : ccsd_top
`default_nettype wire

// [core/ccsd_params.svh]
// constants for the clock configuration select and divider block
`ifndef CCSD_PARAMS_SVH
`define CCSD_PARAMS_SVH
`define CCSD_ADDR_W 4
`define CCSD_ADDR_CTRL 4'h0
`define CCSD_ADDR_DIV 4'h1
`define CCSD_ADDR_FBDIV 4'h2
`define CCSD_ADDR_FRAC 4'h3
`define CCSD_ADDR_PREDIV 4'h4
`define CCSD_ADDR_STATUS 4'h5
`define CCSD_ADDR_DECODE 4'h6
`define CCSD_CTRL_MODE_LSB 0
`define CCSD_CTRL_SRC_BIT 2
`define CCSD_CTRL_SET_BIT 3
`define CCSD_CTRL_DBL_BIT 4
`define CCSD_CTRL_SWMODE_LSB 5
`define CCSD_CTRL_REFSEL_BIT 7
`define CCSD_DIV_W 11
`define CCSD_DIV_MIN 12'h002
`define CCSD_DIV_SMALL_MAX 11'h005
`define CCSD_VCO_MIN_MHZ 1995
`define CCSD_VCO_MAX_MHZ 2600
`define CCSD_LOAD_WORDS 3'h5
`endif

// [core/ccsd_pkg.sv]
// types for the clock configuration select and divider block
`default_nettype none
package ccsd_pkg;
    typedef enum logic [1:0] {
        CCSD_MODE_LOW_BW = 2'b00,
        CCSD_MODE_HIGH_BW = 2'b01,
        CCSD_MODE_SYNTH = 2'b10,
        CCSD_MODE_RSVD = 2'b11
    } ccsd_mode_e;
    typedef enum logic [1:0] {
        CCSD_SW_MAN_PIN = 2'b00,
        CCSD_SW_MAN_REG = 2'b01,
        CCSD_SW_REVERT = 2'b10,
        CCSD_SW_NONREV = 2'b11
    } ccsd_sw_e;
    typedef enum logic [1:0] {
        CCSD_ST_LOAD = 2'b00,
        CCSD_ST_RUN = 2'b01,
        CCSD_ST_IDLE = 2'b10
    } ccsd_state_e;
endpackage : ccsd_pkg
`default_nettype wire

// [test/ccsd_host.sv]
// host and board model: register port master and the two select pins
`default_nettype none
module ccsd_host (
    input wire logic sys_clk,
    input wire logic load_done,
    input wire logic [15:0] reg_rdata,
    output logic [3:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic set_select_pin,
    output logic ref_sel_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        set_select_pin = 1'b0; // pin rests low like its pull-down
        ref_sel_pin = 1'b0;
    end
    // writes wait for the loader, which drops them silently otherwise
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (load_done !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d; // no stale data once the strobe is gone
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task automatic pins(input logic s, input logic r);
        @(posedge sys_clk);
        set_select_pin <= s;
        ref_sel_pin <= r;
    endtask
endmodule // ccsd_host
`default_nettype wire

// [test/ccsd_top_tb.sv]
// self-checking bench for the configuration loader and divider decode
`default_nettype none
module ccsd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ref_a_bad = 1'b0;
    logic ref_b_bad = 1'b0;
    logic xtal_bad = 1'b0;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, fb_div_frac, q;
    logic reg_wr, reg_rd, set_select_pin, ref_sel_pin, mode_reserved, fb_frac_en;
    logic xtal_double, upper_loop_only, upper_from_xtal, ref_inputs_used;
    logic active_ref_b, alarm_pin, load_done;
    logic [1:0] loop_mode;
    logic [11:0] out_div_ratio;
    logic [10:0] fb_div_int;
    logic [7:0] pre_div;
    int err_count = 0;
    int num_checks = 0;
    always #5 sys_clk = ~sys_clk;
    ccsd_host host (.sys_clk(sys_clk), .load_done(load_done), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .set_select_pin(set_select_pin), .ref_sel_pin(ref_sel_pin));
    ccsd_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .set_select_pin(set_select_pin), .ref_sel_pin(ref_sel_pin), .ref_a_bad(ref_a_bad),
        .ref_b_bad(ref_b_bad), .xtal_bad(xtal_bad), .loop_mode(loop_mode),
        .mode_reserved(mode_reserved), .out_div_ratio(out_div_ratio),
        .fb_div_int(fb_div_int), .fb_div_frac(fb_div_frac), .fb_frac_en(fb_frac_en),
        .pre_div(pre_div), .xtal_double(xtal_double), .upper_loop_only(upper_loop_only),
        .upper_from_xtal(upper_from_xtal), .ref_inputs_used(ref_inputs_used),
        .active_ref_b(active_ref_b), .alarm_pin(alarm_pin), .load_done(load_done));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        int n;
        repeat (3) @(posedge sys_clk);
        n = 0;
        while (load_done !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        #1;
        chk({15'h0000, load_done}, 16'h0001); // a loader that never ends counts
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle();
    endtask
    task automatic t_defaults();
        chk({4'h0, out_div_ratio}, 16'h0004);
        chk({5'h00, fb_div_int}, 16'h0050);
        chk({8'h00, pre_div}, 16'h0001);
        chk({14'h0000, loop_mode}, 16'h0000);
        $display("test defaults done");
    endtask
    task automatic t_pin();
        host.wr(4'h0, 16'h0002);
        host.pins(1'b1, 1'b0);
        repeat (2) @(posedge sys_clk);
        #1 chk({15'h0000, load_done}, 16'h0000); // pin edge starts a reload
        settle(); // downstream waits out the reconfiguration
        chk({4'h0, out_div_ratio}, 16'h0008);
        chk({5'h00, fb_div_int}, 16'h0060);
        chk({8'h00, pre_div}, 16'h0002);
        chk({14'h0000, loop_mode}, 16'h0002);
        host.wr(4'h0, 16'h0004);
        settle();
        chk({4'h0, out_div_ratio}, 16'h0004);
        host.wr(4'h0, 16'h000c);
        host.pins(1'b0, 1'b0);
        settle();
        chk({4'h0, out_div_ratio}, 16'h0008);
        host.wr(4'h0, 16'h0000);
        settle();
        chk({4'h0, out_div_ratio}, 16'h0004);
        $display("test set select done");
    endtask
    task automatic t_mode();
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            host.wr(4'h0, {14'h0000, m});
            settle();
            chk({10'h000, mode_reserved, ref_inputs_used, upper_from_xtal, upper_loop_only,
                loop_mode}, {10'h000, m == 2'b11, m != 2'b10, m == 2'b10, m != 2'b00,
                m});
        end
        host.wr(4'h0, 16'h0000);
        $display("test modes done");
    endtask
    task automatic t_div();
        logic [10:0] v;
        logic [11:0] e;
        logic [10:0] vals [12] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h005,
            11'h006, 11'h007, 11'h012, 11'h013, 11'h7fe, 11'h7ff};
        foreach (vals[i]) begin
            v = vals[i];
            e = (v < 11'h003) ? 12'h002 : (v < 11'h006) ? {1'b0, v} : {1'b0, v[10:1], 1'b0};
            host.wr(4'h1, {5'h00, v});
            settle();
            chk({4'h0, out_div_ratio}, {4'h0, e});
            host.rd(4'h6, q);
            chk(q, {4'h0, e});
        end
        host.wr(4'h1, 16'h0004); // back to a ratio that keeps the oscillator in range
        $display("test divider done");
    endtask
    task automatic t_bus();
        host.wr(4'h7, 16'h1234);
        host.rd(4'h1, q);
        chk(q, 16'h0004);
        @(posedge sys_clk);
        #1 chk(reg_rdata, 16'h0000); // data stands one cycle only
        host.rd(4'h7, q);
        chk(q, 16'h0000); // unmapped reads give zero
        host.wr(4'h2, 16'h0123);
        host.wr(4'h3, 16'h8001);
        host.wr(4'h4, 16'h0007);
        host.wr(4'h0, 16'h0012);
        settle();
        chk({5'h00, fb_div_int}, 16'h0123);
        chk({fb_div_frac}, 16'h8001);
        chk({13'h0000, fb_frac_en, xtal_double, 1'b0}, 16'h0006);
        chk({8'h00, pre_div}, 16'h0007);
        host.wr(4'h3, 16'h0000);
        settle();
        chk({15'h0000, fb_frac_en}, 16'h0000);
        $display("test register port done");
    endtask
    task automatic t_alarm_ref();
        @(posedge sys_clk);
        ref_a_bad <= 1'b1;
        settle();
        chk({15'h0000, alarm_pin}, 16'h0001);
        host.rd(4'h5, q);
        chk(q & 16'h0003, 16'h0003);
        @(posedge sys_clk);
        ref_a_bad <= 1'b0;
        xtal_bad <= 1'b1;
        settle();
        host.rd(4'h5, q);
        chk(q & 16'h000f, 16'h0009);
        chk({15'h0000, alarm_pin}, 16'h0001);
        @(posedge sys_clk);
        xtal_bad <= 1'b0;
        host.wr(4'h0, 16'h00a0);
        settle();
        chk({14'h0000, alarm_pin, active_ref_b}, 16'h0001);
        host.wr(4'h0, 16'h0020);
        host.pins(1'b0, 1'b1);
        settle();
        chk({15'h0000, active_ref_b}, 16'h0000); // register select ignores pin
        host.wr(4'h0, 16'h0000);
        settle();
        chk({15'h0000, active_ref_b}, 16'h0001);
        host.wr(4'h0, 16'h0040);
        settle();
        chk({15'h0000, active_ref_b}, 16'h0000); // revertive, a preferred
        @(posedge sys_clk);
        ref_a_bad <= 1'b1;
        settle();
        chk({15'h0000, active_ref_b}, 16'h0001);
        @(posedge sys_clk);
        ref_a_bad <= 1'b0;
        settle();
        chk({15'h0000, active_ref_b}, 16'h0000); // reverts to a
        host.wr(4'h0, 16'h0060);
        @(posedge sys_clk);
        ref_a_bad <= 1'b1;
        settle();
        chk({15'h0000, active_ref_b}, 16'h0001); // non-revertive
        @(posedge sys_clk);
        ref_a_bad <= 1'b0;
        settle();
        chk({15'h0000, active_ref_b}, 16'h0001); // stays on b
        $display("test alarms and reference done");
    endtask
    task automatic t_power();
        host.wr(4'h1, 16'h0010);
        host.wr(4'h0, 16'h0001);
        do_reset();
        chk({4'h0, out_div_ratio}, 16'h0004);
        chk({14'h0000, loop_mode}, 16'h0000);
        host.rd(4'h1, q);
        chk(q, 16'h0004);
        $display("test second power-up done");
    endtask
    initial begin
        #100000;
        err_count++;
        results();
    end
    initial begin
        do_reset();
        t_defaults();
        t_pin();
        t_mode();
        t_div();
        t_bus();
        t_alarm_ref();
        t_power();
        results();
    end
endmodule // ccsd_top_tb
`default_nettype wire
